/* dhp_chk.sv */
// Purpose: port checker for the host port and reset block
// Assumes: pin inputs change well away from the clock edge
// Notes: bound to the top module from the bench
`timescale 1ns/1ns
module dhp_chk #(
    parameter int CANCEL_IN_CYC = 200,
    parameter int CANCEL_OUT_CYC = 400
) (
    input wire logic clk,                     // clock
    input wire logic rst,                     // async reset
    input wire logic hw_reset_line_n,         // reset pin
    input wire logic serial_mode,             // serial select
    input wire logic port_select_n,           // chip select
    input wire logic write_strobe_n,          // write strobe
    input wire logic rx_valid,                // word strobe
    input wire logic rx_is_cmd,               // word is command
    input wire logic [17:0] rx_data,          // received word
    input wire logic core_reset,              // core in reset
    input wire logic ready,                   // port accepting
    input wire logic display_blank,           // blanked
    input wire logic sleep_out,               // sleep-out mode
    input wire logic [23:0] id_bytes,         // loaded id
    input wire logic [7:0] common_voltage_setting // loaded voltage
);
    // slack covers sync flops and the store load
    localparam int LIM = CANCEL_OUT_CYC + 20;
    localparam int REJ = dhp_pkg::RST_REJECT_CYC - 8;
    localparam int GLI = dhp_pkg::RST_GLITCH_CYC - 8;
    localparam logic [23:0] ID_EXP = {dhp_pkg::NV_INIT[7:0],
        dhp_pkg::NV_INIT[15:8], dhp_pkg::NV_INIT[23:16]};
    logic [11:0] low_reg, low_next, high_reg, high_next;
    logic pin_reg, pin_next;

    // pin run lengths saturate so long holds never wrap
    always_comb begin
        low_next = hw_reset_line_n ? 12'h000 : low_reg + {11'h000, ~&low_reg};
        high_next = hw_reset_line_n ? high_reg + {11'h000, ~&high_reg}
                                    : 12'h000;
        pin_next = pin_reg | (low_reg >= REJ);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_reg <= 12'h000;
            high_reg <= 12'h000;
            pin_reg <= 1'b0;
        end else begin
            low_reg <= low_next;
            high_reg <= high_next;
            pin_reg <= pin_next;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_NO_READY_IN_RST: assert property (core_reset && $past(core_reset) |-> !ready)
        else $error("ready high in reset");
    AST_BLANK_IN_RST: assert property (core_reset && $past(core_reset) |-> display_blank)
        else $error("display not blank in reset");
    AST_CANCEL_BOUND: assert property ($fell(core_reset) |-> ##[1:LIM] ready)
        else $error("reset cancel too long");
    AST_SPIKE_REJECT: assert property ($rose(core_reset) |-> low_reg >= REJ)
        else $error("short low pulse took reset");
    AST_LONG_PULSE: assert property (low_reg == 12'd2260 |-> core_reset)
        else $error("long low pulse did not reset");
    AST_GLITCH_HOLD: assert property ($fell(core_reset) && pin_reg |-> high_reg >= GLI)
        else $error("reset ended on a short high blip");
    AST_STORE_LOAD: assert property ($rose(ready) |-> id_bytes == ID_EXP && common_voltage_setting == dhp_pkg::NV_INIT[31:24])
        else $error("store contents not loaded");
    AST_WRITE_LATENCY: assert property ($rose(write_strobe_n) && !port_select_n && !serial_mode && ready |-> ##[3:5] rx_valid)
        else $error("write word not delivered");
    AST_VALID_PULSE: assert property (rx_valid |=> !rx_valid)
        else $error("word strobe longer than one cycle");
    AST_SLEEP_SET: assert property (rx_valid && rx_is_cmd && rx_data[7:0] == dhp_pkg::CMD_SLEEP_OUT |-> ##[0:3] sleep_out)
        else $error("sleep-out command ignored");
    cover property ($rose(core_reset));
    cover property (rx_valid && rx_is_cmd);
    cover property ($rose(sleep_out));
endmodule : dhp_chk

/* dhp_host.sv */
// Purpose: host controller model driving the port pins
// Assumes: called from the bench after a falling clock edge
// Notes: serial clock idles low and runs only inside a frame
`timescale 1ns/1ns
module dhp_host (
    input wire logic clk,             // system clock
    input wire logic [17:0] data_out, // read-back pins
    input wire logic data_oe,         // device drives pins
    output logic hw_reset_line_n,     // reset pin
    output logic port_select_n,       // chip select
    output logic write_strobe_n,      // write strobe
    output logic read_strobe_n,       // read strobe
    output logic cmd_data_select,     // 0 command, 1 data
    output logic [17:0] data_in,      // data pins
    output logic ser_clk,             // serial clock
    output logic ser_din              // serial data
);
    initial begin
        hw_reset_line_n = 1'b1;
        port_select_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        cmd_data_select = 1'b0;
        data_in = 18'h15555;
        ser_clk = 1'b0;
        ser_din = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic pin_low(input int n);
        cyc(1);
        hw_reset_line_n = 1'b0;
        cyc(n);
        hw_reset_line_n = 1'b1;
    endtask : pin_low
    // one word per strobe; released pins show no stale word
    task automatic par_write(input logic dc, input logic [17:0] d);
        cyc(1);
        port_select_n = 1'b0;
        cmd_data_select = dc;
        data_in = d;
        cyc(1);
        write_strobe_n = 1'b0;
        cyc(4);
        write_strobe_n = 1'b1;
        cyc(4);
        port_select_n = 1'b1;
        data_in = ~d;
    endtask : par_write
    // read low well over 45 ns
    task automatic par_read(output logic [17:0] q, output logic oe);
        cyc(1);
        port_select_n = 1'b0;
        cyc(12);
        read_strobe_n = 1'b0;
        cyc(15);
        q = data_out;
        oe = data_oe;
        read_strobe_n = 1'b1;
        cyc(4);
        port_select_n = 1'b1;
    endtask : par_read
    // 125 ns clock, leading select bit in 3-line
    task automatic ser_write(input logic dc, input logic four,
                             input logic [7:0] b);
        logic [8:0] w;
        w = four ? {b, 1'b0} : {dc, b};
        cyc(1);
        port_select_n = 1'b0;
        cmd_data_select = dc;
        #20;
        for (int i = 0; i < (four ? 8 : 9); i++) begin
            ser_din = w[8];
            #62 ser_clk = 1'b1;
            #63 ser_clk = 1'b0;
            w = w << 1;
        end
        #20;
        port_select_n = 1'b1;
        ser_din = ~ser_din;
    endtask : ser_write
endmodule : dhp_host

/* dhp_nv_if.sv */
// Purpose: read port between the reset sequencer and the store
// Assumes: single clock
// Notes: read data appear one cycle after the address
`timescale 1ns/1ns
interface dhp_nv_if;
    logic [dhp_pkg::NV_AW-1:0] addr;
    logic [7:0] rdata;
    modport reader (output addr, input rdata);
    modport store (input addr, output rdata);
endinterface : dhp_nv_if

/* dhp_nv_store.sv */
// Purpose: small nonvolatile settings store, registered read
// Assumes: contents fixed at build time
// Notes: read data come out of a register
`timescale 1ns/1ns
module dhp_nv_store (
    input wire logic clk,          // system clock
    input wire logic rst,          // async reset, active high
    dhp_nv_if.store nv             // read port
);
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ------------------------------------------------------------------
    // word select
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = dhp_pkg::NV_INIT[{nv.addr, 3'h0} +: 8];
    end

    // read register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign nv.rdata = rdata_reg;
endmodule : dhp_nv_store

/* dhp_pkg.sv */
// Purpose: shared constants for the display host port and reset block
// Assumes: 250 MHz system clock
// Notes: times kept in their own unit, cycle counts derived from them
package dhp_pkg;
    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_REJECT_NS = 5000;   // shorter low pulses ignored
    localparam int RST_GLITCH_NS = 1000;   // high blips inside a pulse
    localparam int CANCEL_IN_MS = 5;       // reset cancel, sleep-in
    localparam int CANCEL_OUT_MS = 120;    // reset cancel, sleep-out
    // a least time rounds up to whole cycles
    localparam int RST_REJECT_CYC =
        (RST_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_GLITCH_CYC =
        (RST_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // a longest time rounds down
    localparam int CANCEL_IN_CYC = CANCEL_IN_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CANCEL_OUT_CYC = CANCEL_OUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FILT_W = 12;
    localparam int CANCEL_W = 25;

    // ------------------------------------------------------------------
    // bus widths and modes
    // ------------------------------------------------------------------
    localparam int DATA_W = 18;
    localparam logic [1:0] BUS_W8 = 2'h0;
    localparam logic [1:0] BUS_W9 = 2'h1;
    localparam logic [1:0] BUS_W16 = 2'h2;
    localparam logic [1:0] BUS_W18 = 2'h3;
    localparam int SER_BITS = 8;
    localparam logic [7:0] CMD_SLEEP_IN = 8'h10;
    localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;

    // ------------------------------------------------------------------
    // nonvolatile store layout
    // ------------------------------------------------------------------
    localparam int NV_AW = 2;
    localparam logic [NV_AW-1:0] NV_ID0 = 2'h0;
    localparam logic [NV_AW-1:0] NV_ID1 = 2'h1;
    localparam logic [NV_AW-1:0] NV_ID2 = 2'h2;
    localparam logic [NV_AW-1:0] NV_COMMON_VOLTAGE_SETTING = 2'h3;
    // arbitrary neutral contents
    localparam logic [31:0] NV_INIT = 32'h2A01_5A00;

    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_HOLD = 2'b01,
        RS_LOAD = 2'b10,
        RS_WAIT = 2'b11
    } dhp_rst_state_t;
endpackage : dhp_pkg

/* dhp_top.sv */
// Purpose: host command/data port and hardware reset of a display core
// Assumes: host pins are asynchronous and pass two flip-flops first
// Notes: serial link write only; parallel port reads back rd_data
`timescale 1ns/1ns
module dhp_top #(
    parameter int CANCEL_IN_CYC = dhp_pkg::CANCEL_IN_CYC,
    parameter int CANCEL_OUT_CYC = dhp_pkg::CANCEL_OUT_CYC
) (
    input wire logic clk,                 // 250 MHz system clock
    input wire logic rst,                 // async reset, active high
    input wire logic hw_reset_line_n,     // reset pin, active low
    input wire logic [1:0] bus_width,     // parallel width select
    input wire logic serial_mode,         // 1: serial link in use
    input wire logic serial_4line,        // 1: 4-line, 0: 3-line
    input wire logic port_select_n,       // chip select pin
    input wire logic write_strobe_n,      // parallel write strobe
    input wire logic read_strobe_n,       // parallel read strobe
    input wire logic cmd_data_select,     // 0 command, 1 data
    input wire logic [17:0] data_in,      // parallel data pins in
    input wire logic ser_clk,             // serial clock pin
    input wire logic ser_din,             // serial data pin in
    input wire logic [17:0] rd_data,      // core read-back word
    output logic [17:0] data_out,         // parallel data pins out
    output logic data_oe,                 // parallel data drive enable
    output logic rx_valid,                // one-cycle word strobe
    output logic rx_is_cmd,               // word is a command
    output logic [17:0] rx_data,          // received word
    output logic core_reset,              // core held in reset
    output logic ready,                   // accepting host transfers
    output logic display_blank,           // display blanked
    output logic sleep_out,               // sleep-out mode active
    output logic [23:0] id_bytes,         // loaded id bytes
    output logic [7:0] common_voltage_setting // loaded voltage setting
);
    // ------------------------------------------------------------------
    // pin synchronisers (two flops, then a third for edges)
    // ------------------------------------------------------------------
    localparam int SYW = 25;
    logic [SYW-1:0] pin_raw, sy1_reg, sy2_reg, sy3_reg;
    assign pin_raw = {hw_reset_line_n, port_select_n, write_strobe_n,
        read_strobe_n, cmd_data_select, ser_clk, ser_din, data_in};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sy1_reg <= {SYW{1'b1}};
            sy2_reg <= {SYW{1'b1}};
            sy3_reg <= {SYW{1'b1}};
        end else begin
            sy1_reg <= pin_raw;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
        end
    end

    logic rl_n, cs_n, wr_n, rd_n, dc, sclk, sdin;
    logic [17:0] din;
    assign {rl_n, cs_n, wr_n, rd_n, dc, sclk, sdin, din} = sy2_reg;
    logic wr_rise, rd_fall, rd_rise, sclk_rise;
    assign wr_rise = wr_n & ~sy3_reg[22];
    assign rd_fall = ~rd_n & sy3_reg[21];
    assign rd_rise = rd_n & ~sy3_reg[21];
    assign sclk_rise = sclk & ~sy3_reg[19];

    // bus width masking of a parallel word
    function automatic logic [17:0] width_mask(input logic [1:0] w,
                                               input logic [17:0] d);
        logic [17:0] r;
        r = d;
        if (w == dhp_pkg::BUS_W8) begin
            r = {10'h000, d[7:0]};
        end else if (w == dhp_pkg::BUS_W9) begin
            r = {9'h000, d[8:0]};
        end else if (w == dhp_pkg::BUS_W16) begin
            r = {2'h0, d[15:0]};
        end
        return r;
    endfunction : width_mask

    // ------------------------------------------------------------------
    // reset line filter
    // ------------------------------------------------------------------
    logic [dhp_pkg::FILT_W-1:0] low_cnt_reg, low_cnt_next;
    logic [dhp_pkg::FILT_W-1:0] hi_cnt_reg, hi_cnt_next;
    logic rst_hit_reg, rst_hit_next;

    // low time must reach the reject count before a reset is taken;
    // thereafter a high must persist through the glitch count to end it
    always_comb begin
        low_cnt_next = low_cnt_reg;
        hi_cnt_next = hi_cnt_reg;
        rst_hit_next = rst_hit_reg;
        if (!rst_hit_reg) begin
            hi_cnt_next = '0;
            if (rl_n) begin
                low_cnt_next = '0;
            end else if (low_cnt_reg ==
                    dhp_pkg::FILT_W'(dhp_pkg::RST_REJECT_CYC - 1)) begin
                rst_hit_next = 1'b1;
            end else begin
                low_cnt_next = low_cnt_reg + 1'b1;
            end
        end else begin
            low_cnt_next = '0;
            if (!rl_n) begin
                hi_cnt_next = '0;
            end else if (hi_cnt_reg ==
                    dhp_pkg::FILT_W'(dhp_pkg::RST_GLITCH_CYC - 1)) begin
                rst_hit_next = 1'b0;
            end else begin
                hi_cnt_next = hi_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= '0;
            hi_cnt_reg <= '0;
            rst_hit_reg <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_next;
            hi_cnt_reg <= hi_cnt_next;
            rst_hit_reg <= rst_hit_next;
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer and settings reload
    // ------------------------------------------------------------------
    dhp_nv_if nv ();
    dhp_nv_store u_store (
        .clk(clk),
        .rst(rst),
        .nv(nv)
    );

    dhp_pkg::dhp_rst_state_t st_reg, st_next;
    logic [dhp_pkg::CANCEL_W-1:0] cnt_reg, cnt_next;
    logic [2:0] ld_reg, ld_next;
    logic was_out_reg, was_out_next;
    logic sleep_reg, sleep_next;
    logic [23:0] id_reg, id_next;
    logic [7:0] common_voltage_setting_reg, common_voltage_setting_next;
    logic cmd_ok;
    logic [17:0] rx_word;
    logic rx_take;
    logic rx_cmd;

    assign nv.addr = ld_reg[dhp_pkg::NV_AW-1:0];

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        ld_next = ld_reg;
        was_out_next = was_out_reg;
        sleep_next = sleep_reg;
        id_next = id_reg;
        common_voltage_setting_next = common_voltage_setting_reg;
        case (st_reg)
            dhp_pkg::RS_RUN: begin
                if (rst_hit_reg) begin
                    was_out_next = sleep_reg;
                    st_next = dhp_pkg::RS_HOLD;
                end else if (cmd_ok && rx_cmd &&
                        rx_word[7:0] == dhp_pkg::CMD_SLEEP_OUT) begin
                    sleep_next = 1'b1;
                end else if (cmd_ok && rx_cmd &&
                        rx_word[7:0] == dhp_pkg::CMD_SLEEP_IN) begin
                    sleep_next = 1'b0;
                end
            end
            dhp_pkg::RS_HOLD: begin
                sleep_next = 1'b0;
                ld_next = 3'h0;
                if (!rst_hit_reg) begin
                    st_next = dhp_pkg::RS_LOAD;
                end
            end
            dhp_pkg::RS_LOAD: begin
                ld_next = ld_reg + 3'h1;
                if (ld_reg != 3'h0) begin
                    if (ld_reg[1:0] == 2'h0) begin
                        common_voltage_setting_next = nv.rdata;
                    end else begin
                        id_next = {id_reg[15:0], nv.rdata};
                    end
                end
                if (ld_reg == 3'h4) begin
                    cnt_next = '0;
                    st_next = dhp_pkg::RS_WAIT;
                end
            end
            default: begin
                cnt_next = cnt_reg + 1'b1;
                if (rst_hit_reg) begin
                    st_next = dhp_pkg::RS_HOLD;
                end else if (cnt_reg == dhp_pkg::CANCEL_W'(was_out_reg ?
                        CANCEL_OUT_CYC - 6 : CANCEL_IN_CYC - 6)) begin
                    st_next = dhp_pkg::RS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= dhp_pkg::RS_HOLD;
            cnt_reg <= '0;
            ld_reg <= 3'h0;
            was_out_reg <= 1'b0;
            sleep_reg <= 1'b0;
            id_reg <= 24'h000000;
            common_voltage_setting_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ld_reg <= ld_next;
            was_out_reg <= was_out_next;
            sleep_reg <= sleep_next;
            id_reg <= id_next;
            common_voltage_setting_reg <= common_voltage_setting_next;
        end
    end

    // ------------------------------------------------------------------
    // host receive: parallel strobe and serial shifter
    // ------------------------------------------------------------------
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic sdc_reg, sdc_next;
    logic rxv_reg, rxv_next, rxc_reg, rxc_next;
    logic [17:0] rxd_reg, rxd_next;
    logic [17:0] dout_reg, dout_next;
    logic doe_reg, doe_next;
    logic ser_bit;
    logic [3:0] ser_last;

    // 3-line has a leading select bit
    assign ser_last = serial_4line ? 4'(dhp_pkg::SER_BITS - 1)
                                   : 4'(dhp_pkg::SER_BITS);
    assign ser_bit = serial_mode && !cs_n && sclk_rise;

    // word assembly, shared by both links
    always_comb begin
        rx_take = 1'b0;
        rx_cmd = ~dc;
        rx_word = '0;
        if (!serial_mode) begin
            rx_take = !cs_n && wr_rise;
            rx_word = width_mask(bus_width, din);
        end else begin
            rx_take = ser_bit && bit_reg == ser_last;
            rx_cmd = serial_4line ? ~dc : ~sdc_reg;
            rx_word = {10'h000, sh_reg[6:0], sdin};
        end
    end

    // commands only taken while the core runs; others dropped
    assign cmd_ok = rx_take && st_reg == dhp_pkg::RS_RUN;

    always_comb begin
        bit_next = bit_reg;
        sh_next = sh_reg;
        sdc_next = sdc_reg;
        rxv_next = cmd_ok;
        rxc_next = rxc_reg;
        rxd_next = rxd_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        if (cs_n || !serial_mode) begin
            bit_next = 4'h0;
        end else if (ser_bit) begin
            bit_next = (bit_reg == ser_last) ? 4'h0 : bit_reg + 4'h1;
            sh_next = {sh_reg[6:0], sdin};
            if (!serial_4line && bit_reg == 4'h0) begin
                sdc_next = sdin;
            end
        end
        if (cmd_ok) begin
            rxc_next = rx_cmd;
            rxd_next = rx_word;
        end
        // read-back drive while the read strobe is low
        if (!serial_mode && !cs_n && rd_fall &&
                st_reg == dhp_pkg::RS_RUN) begin
            dout_next = width_mask(bus_width, rd_data);
            doe_next = 1'b1;
        end else if (rd_rise || cs_n) begin
            doe_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            sdc_reg <= 1'b0;
            rxv_reg <= 1'b0;
            rxc_reg <= 1'b0;
            rxd_reg <= 18'h00000;
            dout_reg <= 18'h00000;
            doe_reg <= 1'b0;
        end else begin
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            sdc_reg <= sdc_next;
            rxv_reg <= rxv_next;
            rxc_reg <= rxc_next;
            rxd_reg <= rxd_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, each from a flop
    // ------------------------------------------------------------------
    logic crst_reg, rdy_reg, blank_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crst_reg <= 1'b1;
            rdy_reg <= 1'b0;
            blank_reg <= 1'b1;
        end else begin
            crst_reg <= st_next == dhp_pkg::RS_HOLD;
            rdy_reg <= st_next == dhp_pkg::RS_RUN;
            blank_reg <= st_next != dhp_pkg::RS_RUN || !sleep_next;
        end
    end

    assign data_out = dout_reg;
    assign data_oe = doe_reg;
    assign rx_valid = rxv_reg;
    assign rx_is_cmd = rxc_reg;
    assign rx_data = rxd_reg;
    assign core_reset = crst_reg;
    assign ready = rdy_reg;
    assign display_blank = blank_reg;
    assign sleep_out = sleep_reg;
    assign id_bytes = id_reg;
    assign common_voltage_setting = common_voltage_setting_reg;
endmodule : dhp_top

/* display_host_port_and_reset_test.sv */
// Purpose: self-checking bench for the host port and reset block
// Assumes: shortened cancel times; pin pulses keep real lengths
// Notes: host model owns every pin; bench owns mode inputs
`timescale 1ns/1ns
module display_host_port_and_reset_test;
    localparam int CIN = 200;
    localparam int COUT = 400;
    localparam int W [4] = '{8, 9, 16, 18};
    localparam logic [8:0] SV [4] = '{9'h0A5, 9'h13C, 9'h096, 9'h15A};
    logic clk, rst, serial_mode, serial_4line, data_oe, rx_valid;
    logic rx_is_cmd, core_reset, ready, display_blank, sleep_out;
    logic hw_reset_line_n, port_select_n, write_strobe_n, read_strobe_n;
    logic cmd_data_select, ser_clk, ser_din;
    logic [1:0] bus_width;
    logic [17:0] data_in, rd_data, data_out, rx_data;
    logic [23:0] id_bytes;
    logic [7:0] common_voltage_setting;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;

    dhp_top #(.CANCEL_IN_CYC(CIN), .CANCEL_OUT_CYC(COUT)) u_dhp_top (.*);
    dhp_host u_dhp_host (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ceiling well above the roughly 9k cycles the tests need
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [23:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // no command before ready; cycles to ready, bounded
    task automatic wait_ready(output int n);
        n = 0;
        while (core_reset !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_ready
    // power-on defaults and store load
    task automatic t_boot;
        int n;
        chk("core_reset", core_reset, 24'h1);
        chk("blank", display_blank, 24'h1);
        chk("ready", ready, 24'h0);
        rst = 1'b0;
        wait_ready(n);
        chk("cancel_in", n >= CIN - 20 && n <= CIN + 20, 24'h1);
        chk("id", id_bytes, {dhp_pkg::NV_INIT[7:0], dhp_pkg::NV_INIT[15:8], dhp_pkg::NV_INIT[23:16]});
        chk("common_voltage_setting", common_voltage_setting, dhp_pkg::NV_INIT[31:24]);
        chk("blank_in", display_blank, 24'h1);
    endtask : t_boot
    // every bus width, write then read back
    task automatic t_widths;
        logic [17:0] q, m;
        logic oe;
        rd_data = 18'h2B5C3;
        for (int i = 0; i < 4; i++) begin
            bus_width = 2'(i);
            m = 18'h3FFFF >> (18 - W[i]);
            u_dhp_host.par_write(1'b1, 18'h2B5C3);
            u_dhp_host.cyc(2);
            chk("rx_data", rx_data, m & 18'h2B5C3);
            chk("rx_is_cmd", rx_is_cmd, 24'h0);
            u_dhp_host.par_read(q, oe);
            chk("rd_oe", oe, 24'h1);
            chk("rd_data", q, m & 18'h2B5C3);
            u_dhp_host.cyc(2);
            chk("oe_off", data_oe, 24'h0);
        end
    endtask : t_widths
    // 4-line then 3-line bytes, command and data; no serial read
    task automatic t_serial;
        logic [17:0] q;
        logic oe;
        serial_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            serial_4line = (i < 2);
            u_dhp_host.ser_write(SV[i][8], serial_4line, SV[i][7:0]);
            u_dhp_host.cyc(2);
            chk("ser_data", rx_data, {10'h000, SV[i][7:0]});
            chk("ser_cmd", rx_is_cmd, {23'h0, ~SV[i][8]});
        end
        u_dhp_host.par_read(q, oe);
        chk("ser_no_oe", oe, 24'h0);
        serial_mode = 1'b0;
    endtask : t_serial
    // sleep-out, then a full pin reset picks the long cancel
    task automatic t_sleep;
        int n;
        u_dhp_host.par_write(1'b0, {10'h000, dhp_pkg::CMD_SLEEP_OUT});
        u_dhp_host.cyc(4);
        chk("cmd", rx_is_cmd, 24'h1);
        chk("sleep_out", sleep_out, 24'h1);
        chk("blank_run", display_blank, 24'h0);
        u_dhp_host.pin_low(2600);
        chk("pin_rst", core_reset, 24'h1);
        chk("blank_rst", display_blank, 24'h1);
        chk("ready_rst", ready, 24'h0);
        wait_ready(n);
        chk("cancel_out", n >= COUT - 20 && n <= COUT + 20, 24'h1);
        chk("default", sleep_out, 24'h0);
    endtask : t_sleep
    // short spike ignored; blip inside a pulse does not split it
    task automatic t_spike;
        int n;
        u_dhp_host.pin_low(1000);
        u_dhp_host.cyc(300);
        chk("spike", core_reset, 24'h0);
        chk("spike_rdy", ready, 24'h1);
        u_dhp_host.pin_low(1500);
        u_dhp_host.cyc(100);
        u_dhp_host.pin_low(1000);
        chk("glitch", core_reset, 24'h1);
        wait_ready(n);
        chk("cancel_g", n <= CIN + 20, 24'h1);
    endtask : t_spike
    initial begin
        rst = 1'b1;
        bus_width = 2'h3;
        serial_mode = 1'b0;
        serial_4line = 1'b1;
        rd_data = 18'h00000;
        repeat (10) @(negedge clk);
        t_boot();
        t_widths();
        t_serial();
        t_sleep();
        t_spike();
        end_sim();
    end
endmodule : display_host_port_and_reset_test

bind dhp_top dhp_chk #(.CANCEL_IN_CYC(CANCEL_IN_CYC),
    .CANCEL_OUT_CYC(CANCEL_OUT_CYC)) u_dhp_chk (.*);
